// *** raw_parallel_sensor_capture.sv ***
`timescale 1ns/1ps
// Functional notes
// RULE_01: accept up to 14-bit raw pixel samples
// RULE_02: software picks sample width, 8 to 16
// RULE_03: optional inversion of incoming data bits
// RULE_04: one bit sets sync pins in or out
// RULE_05: generated vsync: width and half-lines per frame
// RULE_06: generated hsync: width and pixels per line
// RULE_07: separate vsync and hsync polarity, both directions
// RULE_08: sensor drives both syncs when inputs
// RULE_09: sensor drives field id in field mode
// RULE_10: field id optionally latched on vsync
// RULE_11: optional field id polarity inversion
// RULE_12: external write enable gates capture when used
// RULE_13: write enable AND or OR window test
// RULE_14: sample on rising or falling pixel clock
// RULE_15: software programs the frame window always
// RULE_16: 16-bit words, zero-filled, earlier pixel low
// RULE_17: optional A-law 10-to-8-bit compression
// RULE_18: packed mode: four bytes, first lowest
// RULE_19: timing from external or internal syncs
// RULE_20: line count restarts on vsync, pixels on hsync
module raw_parallel_sensor_capture (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pixel_clock,
    input wire logic [13:0] raw_pixel_bus,
    input wire logic field_or_write_enable_pin,
    input wire logic cam_vertical_sync_i,
    output logic cam_vertical_sync_o,
    output logic cam_vertical_sync_oe,
    input wire logic cam_horizontal_sync_i,
    output logic cam_horizontal_sync_o,
    output logic cam_horizontal_sync_oe,
    output logic [31:0] mem_wdata,
    output logic mem_wvalid,
    output logic field_id
);
    raw_capture_pkg::ctrl_t ctrl_q;
    logic [31:0] sync_width_q;
    logic [31:0] frame_size_q;
    logic [31:0] win_h_q;
    logic [31:0] win_v_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    raw_capture_pkg::pins_t meta_q;
    raw_capture_pkg::pins_t pins_q;
    logic pclk_prev_q;
    logic vs_prev_q;
    logic hs_prev_q;
    logic [15:0] px_q;
    logic [15:0] ln_q;
    logic [15:0] gen_px_q;
    logic [15:0] gen_hl_q;
    logic gen_vs_q;
    logic gen_hs_q;
    logic field_latched_q;
    logic [31:0] acc_q;
    logic [1:0] slot_q;
    logic [31:0] mem_wdata_q;
    logic mem_wvalid_q;
    logic field_id_q;
    logic vs_o_q;
    logic hs_o_q;
    logic sync_oe_q;

    // register field views
    wire [15:0] hsync_pulse_width = sync_width_q[15:0];
    wire [15:0] vsync_pulse_width = sync_width_q[31:16];
    wire [15:0] pixels_per_line = frame_size_q[15:0];
    wire [15:0] half_lines_per_frame = frame_size_q[31:16];
    wire [15:0] window_start_pixel = win_h_q[15:0];
    wire [15:0] window_pixel_count = win_h_q[31:16];
    wire [15:0] window_start_line = win_v_q[15:0];
    wire [15:0] window_line_count = win_v_q[31:16];

    // apb decode; one wait state, answer in the second access cycle
    wire acc_phase = psel & penable;
    wire wr_go = acc_phase & pready_q & pwrite;
    wire sel_ctrl = paddr == raw_capture_pkg::CTRL_OFS;
    wire sel_sw = paddr == raw_capture_pkg::SYNC_WIDTH_OFS;
    wire sel_fs = paddr == raw_capture_pkg::FRAME_SIZE_OFS;
    wire sel_wh = paddr == raw_capture_pkg::WIN_H_OFS;
    wire sel_wv = paddr == raw_capture_pkg::WIN_V_OFS;
    wire sel_st = paddr == raw_capture_pkg::STATUS_OFS;
    wire mapped = sel_ctrl | sel_sw | sel_fs | sel_wh | sel_wv | sel_st;
    wire st_write = sel_st & pwrite;
    wire in_window;
    // status: line count, window flag, field id, sync drive
    wire [31:0] status_word = {ln_q, 13'h0000, in_window, field_id_q, sync_oe_q};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_q :
                         sel_sw ? sync_width_q :
                         sel_fs ? frame_size_q :
                         sel_wh ? win_h_q :
                         sel_wv ? win_v_q :
                         sel_st ? status_word : 32'h0000_0000;

    // bus answer flops
    // read data is zero outside the answer so a stale word never leaks
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= acc_phase & ~pready_q;
            prdata_q <= (acc_phase & ~pready_q & ~pwrite) ? rd_mux : 32'h0000_0000;
            pslverr_q <= acc_phase & ~pready_q & (~mapped | st_write);
        end
    end

    // writable registers; the status word is read only
    // reserved control bits read back as zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_q <= raw_capture_pkg::CTRL_RST;
            sync_width_q <= raw_capture_pkg::SYNC_WIDTH_RST;
            frame_size_q <= raw_capture_pkg::FRAME_SIZE_RST;
            win_h_q <= raw_capture_pkg::WIN_H_RST;
            win_v_q <= raw_capture_pkg::WIN_V_RST;
        end else if (wr_go) begin
            if (sel_ctrl) begin
                ctrl_q <= {13'h0000, pwdata[18:0]};
            end
            if (sel_sw) begin
                sync_width_q <= pwdata;
            end
            if (sel_fs) begin
                frame_size_q <= pwdata;
            end
            if (sel_wh) begin
                win_h_q <= pwdata; // RULE_15
            end
            if (sel_wv) begin
                win_v_q <= pwdata; // RULE_15
            end
        end
    end

    // all pins cross together, so clock and data keep their relative timing
    // the sensor must hold data three system clocks around the chosen edge
    wire raw_capture_pkg::pins_t pins_in = {pixel_clock, cam_vertical_sync_i,
        cam_horizontal_sync_i, field_or_write_enable_pin, raw_pixel_bus}; // RULE_01
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            pins_q <= '0;
            pclk_prev_q <= 1'b0;
        end else begin
            meta_q <= pins_in;
            pins_q <= meta_q;
            pclk_prev_q <= pins_q.pclk;
        end
    end

    // pixel clock edge pick
    // the detector resets low like the idle pin, so reset makes no false tick
    wire pclk_rise = pins_q.pclk & ~pclk_prev_q;
    wire pclk_fall = ~pins_q.pclk & pclk_prev_q;
    wire tick = ctrl_q.pixel_clock_edge_select ? pclk_fall : pclk_rise; // RULE_14

    // sync sources: pins in input mode, own generator in output mode
    wire ext_vs = pins_q.vsync ^ ctrl_q.vsync_polarity; // RULE_07 RULE_08
    wire ext_hs = pins_q.hsync ^ ctrl_q.hsync_polarity; // RULE_07 RULE_08
    wire vs_act = ctrl_q.sync_direction_out ? gen_vs_q : ext_vs; // RULE_04 RULE_19
    wire hs_act = ctrl_q.sync_direction_out ? gen_hs_q : ext_hs; // RULE_04 RULE_19
    wire vs_rise = tick & vs_act & ~vs_prev_q;
    wire hs_rise = tick & hs_act & ~hs_prev_q;

    // internal timing generator, advanced by pixel clock edges
    wire [15:0] line_last = pixels_per_line - 16'h0001;
    // an odd line length puts the mid-line half step half a pixel early
    wire [15:0] half_last = (pixels_per_line >> 1) - 16'h0001;
    wire gen_eol = gen_px_q == line_last;
    wire gen_half = gen_eol | (gen_px_q == half_last);
    wire gen_eof = gen_hl_q == half_lines_per_frame - 16'h0001;
    wire [16:0] vs_halves = {vsync_pulse_width, 1'b0};
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gen_px_q <= 16'h0000;
            gen_hl_q <= 16'h0000;
            gen_vs_q <= 1'b0;
            gen_hs_q <= 1'b0;
        end else begin
            if (!ctrl_q.sync_direction_out) begin
                gen_px_q <= 16'h0000;
                gen_hl_q <= 16'h0000;
            end else if (tick) begin
                gen_px_q <= gen_eol ? 16'h0000 : gen_px_q + 16'h0001; // RULE_06
                if (gen_half) begin
                    gen_hl_q <= gen_eof ? 16'h0000 : gen_hl_q + 16'h0001; // RULE_05
                end
            end
            gen_hs_q <= ctrl_q.sync_direction_out & (gen_px_q < hsync_pulse_width); // RULE_06
            gen_vs_q <= ctrl_q.sync_direction_out & ({1'b0, gen_hl_q} < vs_halves); // RULE_05
        end
    end

    // sync pin drivers; enable follows the direction bit
    // in input mode the generator idles, so the levels sit at their inactive polarity
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vs_o_q <= 1'b0;
            hs_o_q <= 1'b0;
            sync_oe_q <= 1'b0;
        end else begin
            vs_o_q <= gen_vs_q ^ ctrl_q.vsync_polarity; // RULE_07
            hs_o_q <= gen_hs_q ^ ctrl_q.hsync_polarity; // RULE_07
            sync_oe_q <= ctrl_q.sync_direction_out; // RULE_04
        end
    end

    // position of the pixel on this tick; the pixel that brings a sync edge is index 0,
    // so the window test never judges it by the previous line's count
    wire [15:0] px_cur = hs_rise ? 16'h0000 : px_q + 16'h0001; // RULE_20
    wire [15:0] ln_cur = vs_rise ? 16'h0000 :
                         hs_rise ? ln_q + 16'h0001 : ln_q; // RULE_20

    // frame position counters; they move only on a tick, so a stopped clock freezes them
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vs_prev_q <= 1'b0;
            hs_prev_q <= 1'b0;
            px_q <= 16'h0000;
            ln_q <= 16'h0000;
        end else if (tick) begin
            vs_prev_q <= vs_act;
            hs_prev_q <= hs_act;
            px_q <= px_cur; // RULE_20
            ln_q <= ln_cur; // RULE_20
        end
    end

    // frame window test, sums kept one bit wider against wrap
    wire [16:0] px_end = {1'b0, window_start_pixel} + {1'b0, window_pixel_count};
    wire [16:0] ln_end = {1'b0, window_start_line} + {1'b0, window_line_count};
    assign in_window = (px_cur >= window_start_pixel) & ({1'b0, px_cur} < px_end) &
                       (ln_cur >= window_start_line) & ({1'b0, ln_cur} < ln_end);

    // field id and write enable share one pin; field mode takes precedence
    wire field_raw = pins_q.field_wen ^ ctrl_q.field_polarity; // RULE_11 RULE_09
    wire field_now = ctrl_q.field_latch_mode ? field_latched_q : field_raw; // RULE_10
    wire ext_wen = pins_q.field_wen & ~ctrl_q.field_mode_enable;
    wire wen_and = ext_wen & in_window;
    wire wen_or = ext_wen | in_window;
    wire wen_mix = ctrl_q.write_enable_combine_logic ? wen_or : wen_and; // RULE_13
    wire qual = ctrl_q.ext_write_enable_use ? wen_mix : in_window; // RULE_12
    // capture_enable low stops every word, a partial one included
    wire take = tick & qual & ctrl_q.capture_enable;

    // latched field id moves only on an active vsync edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            field_latched_q <= 1'b0;
            field_id_q <= 1'b0;
        end else begin
            if (vs_rise) begin
                field_latched_q <= field_raw; // RULE_10
            end
            field_id_q <= ctrl_q.field_mode_enable & field_now;
        end
    end

    // sample width mask and data polarity
    // codes above eight clamp to sixteen bits rather than wrap
    wire [3:0] wcode = ctrl_q.sample_width_select;
    wire [4:0] wbits = (wcode > raw_capture_pkg::WIDTH_CODE_MAX) ? raw_capture_pkg::WIDTH_MAX :
                       raw_capture_pkg::WIDTH_BASE + {1'b0, wcode}; // RULE_02
    wire [15:0] wmask = 16'hFFFF >> (raw_capture_pkg::WIDTH_MAX - wbits); // RULE_02
    wire [13:0] pix_pol = pins_q.pixels ^ {14{ctrl_q.data_polarity_invert}}; // RULE_03
    wire [15:0] pix16 = {2'b00, pix_pol} & wmask; // RULE_16

    // segment compression: linear below 64, then 5-bit mantissa per octave
    function automatic logic [7:0] alaw10(input logic [9:0] x);
        logic [7:0] y;
        y = {2'b00, x[5:0]};
        if (x[9]) begin
            y = {3'h5, x[8:4]};
        end else if (x[8]) begin
            y = {3'h4, x[7:3]};
        end else if (x[7]) begin
            y = {3'h3, x[6:2]};
        end else if (x[6]) begin
            y = {3'h2, x[5:1]};
        end
        return y;
    endfunction

    wire [7:0] comp = alaw10(pix16[9:0]); // RULE_17
    wire [7:0] byte_val = ctrl_q.alaw_enable ? comp : pix16[7:0];
    wire [15:0] half_val = ctrl_q.alaw_enable ? {8'h00, comp} : pix16;
    wire [1:0] slot_last = ctrl_q.pack8_enable ? 2'h3 : 2'h1;
    // a vsync edge pixel opens a fresh word; the partial word before it is lost
    wire [1:0] slot_cur = vs_rise ? 2'h0 : slot_q;
    wire word_done = take & (slot_cur == slot_last);
    // new pixels shift in at the top so the first one ends lowest
    wire [31:0] acc_pack = {byte_val, acc_q[31:8]}; // RULE_18
    wire [31:0] acc_half = {half_val, acc_q[31:16]}; // RULE_16
    wire [31:0] acc_next = ctrl_q.pack8_enable ? acc_pack : acc_half;

    // word assembly; a partial word is dropped at frame start so frames stay aligned
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            acc_q <= 32'h0000_0000;
            slot_q <= 2'h0;
            mem_wdata_q <= 32'h0000_0000;
            mem_wvalid_q <= 1'b0;
        end else begin
            mem_wvalid_q <= word_done;
            if (!ctrl_q.capture_enable) begin
                slot_q <= 2'h0;
            end else if (take) begin
                acc_q <= acc_next;
                slot_q <= word_done ? 2'h0 : slot_cur + 2'h1;
                if (word_done) begin
                    mem_wdata_q <= acc_next; // RULE_16 RULE_18
                end
            end else if (vs_rise) begin
                slot_q <= 2'h0;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cam_vertical_sync_o = vs_o_q;
    assign cam_horizontal_sync_o = hs_o_q;
    assign cam_vertical_sync_oe = sync_oe_q;
    assign cam_horizontal_sync_oe = sync_oe_q;
    assign mem_wdata = mem_wdata_q;
    assign mem_wvalid = mem_wvalid_q;
    assign field_id = field_id_q;
endmodule

// *** raw_capture_pkg.sv ***
package raw_capture_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] SYNC_WIDTH_OFS = 8'h04;
    localparam logic [7:0] FRAME_SIZE_OFS = 8'h08;
    localparam logic [7:0] WIN_H_OFS = 8'h0C;
    localparam logic [7:0] WIN_V_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0006_0000;
    localparam logic [31:0] SYNC_WIDTH_RST = 32'h0002_0010;
    localparam logic [31:0] FRAME_SIZE_RST = 32'h0020_0040;
    localparam logic [31:0] WIN_H_RST = 32'h0000_0000;
    localparam logic [31:0] WIN_V_RST = 32'h0000_0000;

    // sample width field: width is WIDTH_BASE plus the code, at most WIDTH_MAX
    localparam logic [4:0] WIDTH_BASE = 5'h08;
    localparam logic [4:0] WIDTH_MAX = 5'h10;
    localparam logic [3:0] WIDTH_CODE_MAX = 4'h8;

    // pixel bus and synchronised pin geometry
    localparam int PIX_W = 14;
    localparam int SYNC_W = PIX_W + 4;

    // control register layout, bit 0 at the bottom
    typedef struct packed {
        logic [12:0] rsvd;
        logic [3:0] sample_width_select;
        logic [1:0] input_format_select;
        logic pack8_enable;
        logic alaw_enable;
        logic pixel_clock_edge_select;
        logic write_enable_combine_logic;
        logic ext_write_enable_use;
        logic field_polarity;
        logic field_latch_mode;
        logic field_mode_enable;
        logic hsync_polarity;
        logic vsync_polarity;
        logic sync_direction_out;
        logic data_polarity_invert;
        logic capture_enable;
    } ctrl_t;

    // pins as seen after the synchroniser
    typedef struct packed {
        logic pclk;
        logic vsync;
        logic hsync;
        logic field_wen;
        logic [PIX_W-1:0] pixels;
    } pins_t;
endpackage

// *** raw_capture_monitor.sv ***
`timescale 1ns/1ps
module raw_capture_monitor (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cam_vertical_sync_oe,
    input wire logic cam_horizontal_sync_oe,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_wvalid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // request decode; status is read only, so a write there is refused too
    wire acc_cyc = psel && penable && !pready;
    wire bad_adr = paddr > 8'h14 || (pwrite && paddr == raw_capture_pkg::STATUS_OFS);
    wire ctrl_wr = psel && penable && pready && pwrite && paddr == raw_capture_pkg::CTRL_OFS;
    a_one_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("answer not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read answer");
    a_refuse_bad: assert property (acc_cyc && bad_adr |=> pslverr)
        else $error("bad access not refused");
    a_oe_pair: assert property (cam_vertical_sync_oe == cam_horizontal_sync_oe)
        else $error("sync enables differ");
    a_oe_follows: assert property (ctrl_wr |-> ##3
        cam_vertical_sync_oe == $past(pwdata[2], 3))
        else $error("sync enable ignores control write");
    a_word_gap: assert property (mem_wvalid |=> !mem_wvalid [*2])
        else $error("words too close");
    a_word_hold: assert property ($changed(mem_wdata) |-> mem_wvalid)
        else $error("word changed without valid");
    c_word: cover property (mem_wvalid);
    c_refused: cover property (pslverr);
    c_sync_out: cover property ($rose(cam_vertical_sync_oe));
endmodule
bind raw_parallel_sensor_capture raw_capture_monitor raw_capture_monitor_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cam_vertical_sync_oe(cam_vertical_sync_oe),
    .cam_horizontal_sync_oe(cam_horizontal_sync_oe),
    .mem_wdata(mem_wdata), .mem_wvalid(mem_wvalid));

// *** sensor_model.sv ***
`timescale 1ns/1ps
module sensor_model (
    output logic pixel_clock,
    output logic [13:0] raw_pixel_bus,
    output logic vsync,
    output logic hsync,
    output logic field_pin
);
    logic [14:0] px_q[$];
    // idle: clock low, syncs inactive
    initial begin
        pixel_clock = 1'b0;
        raw_pixel_bus = 14'h0;
        vsync = 1'b0;
        hsync = 1'b0;
        field_pin = 1'b0;
    end
    // one line, bit 14 on the field pin; the unused edge sees inverted data
    // so a wrong edge choice shows; the clock stands still after the line
    task automatic send_line(input logic fall);
        logic [14:0] p;
        int i;
        #1;
        for (i = 0; px_q.size() > 0; i++) begin
            p = px_q.pop_front();
            field_pin = p[14];
            vsync = (i == 0);
            hsync = (i == 0);
            raw_pixel_bus = fall ? ~p[13:0] : p[13:0];
            #12 pixel_clock = 1'b1;
            #12 raw_pixel_bus = ~raw_pixel_bus;
            #12 pixel_clock = 1'b0;
            #12;
        end
        // released lines read as the inverse, not a stale copy
        raw_pixel_bus = ~raw_pixel_bus;
        field_pin = ~field_pin;
    endtask
endmodule

// *** raw_parallel_sensor_capture_bench.sv ***
`timescale 1ns/1ps
module raw_parallel_sensor_capture_bench;
    logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, er, mem_wvalid, field_id;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, mem_wdata, rd, r, acc;
    logic vs_o, vs_oe, hs_o, hs_oe, m_pclk, m_vs, m_hs, m_fld, f;
    logic [13:0] m_pix;
    logic [31:0] got[$], exp_q[$], rst_tab[5];
    int bad_count, compares, cyc, nh, nv;

    sensor_model sensor_model_inst (.pixel_clock(m_pclk), .raw_pixel_bus(m_pix),
        .vsync(m_vs), .hsync(m_hs), .field_pin(m_fld));
    raw_parallel_sensor_capture raw_parallel_sensor_capture_inst (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pixel_clock(m_pclk), .raw_pixel_bus(m_pix), .field_or_write_enable_pin(m_fld),
        .cam_vertical_sync_i(vs_oe ? vs_o : m_vs), .cam_vertical_sync_o(vs_o),
        .cam_vertical_sync_oe(vs_oe), .cam_horizontal_sync_i(hs_oe ? hs_o : m_hs),
        .cam_horizontal_sync_o(hs_o), .cam_horizontal_sync_oe(hs_oe),
        .mem_wdata(mem_wdata), .mem_wvalid(mem_wvalid), .field_id(field_id));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // words leaving the block, and a guard against a hang
    always @(posedge sys_clk) begin
        if (mem_wvalid === 1'b1) got.push_back(mem_wdata);
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one transfer, held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    function automatic logic [31:0] cw(input logic [3:0] wc, input logic [12:0] b);
        cw = {13'h0, wc, 2'h0, b};
    endfunction
    // segment and mantissa; small values pass unchanged
    function automatic logic [7:0] al(input logic [9:0] x);
        if (x < 10'h040) al = x[7:0];
        else if (x < 10'h080) al = {3'h2, x[5:1]};
        else if (x < 10'h100) al = {3'h3, x[6:2]};
        else if (x < 10'h200) al = {3'h4, x[7:3]};
        else al = {3'h5, x[8:4]};
    endfunction
    // random line; r picks width, inversion, edge, write enable use and logic, packing
    task automatic capture(input logic [31:0] r);
        logic [15:0] v;
        logic [14:0] p;
        logic ok, win;
        int n;
        n = 0;
        exp_q.delete();
        apb(1'b1, raw_capture_pkg::WIN_H_OFS, {12'h0, r[11:8], 14'h0, r[6:5]});
        apb(1'b1, raw_capture_pkg::WIN_V_OFS, 32'hFFFF_0000);
        apb(1'b1, raw_capture_pkg::CTRL_OFS,
            cw(4'(r[15:12] % 9), {r[4], r[4], r[1], r[3], r[2], 6'h0, r[0], 1'b1}));
        for (int i = 0; i < 14; i++) begin
            p = 15'($urandom);
            sensor_model_inst.px_q.push_back(p);
            win = i >= r[6:5] && i < r[6:5] + r[11:8];
            ok = r[2] ? (r[3] ? (win || p[14]) : (win && p[14])) : win;
            v = {2'h0, r[0] ? ~p[13:0] : p[13:0]} & 16'((32'h1 << (8 + r[15:12] % 9)) - 1);
            if (ok) begin
                acc = r[4] ? {al(v[9:0]), acc[31:8]} : {v, acc[31:16]};
                n++;
                if (n == (r[4] ? 4 : 2)) begin
                    exp_q.push_back(acc);
                    n = 0;
                end
            end
        end
        got.delete();
        sensor_model_inst.send_line(r[1]);
        repeat (20) @(posedge sys_clk);
        chk("word count", 32'(got.size()), 32'(exp_q.size()));
        foreach (exp_q[j]) chk("word", got[j], exp_q[j]);
    endtask

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst_tab = '{raw_capture_pkg::CTRL_RST, raw_capture_pkg::SYNC_WIDTH_RST,
            raw_capture_pkg::FRAME_SIZE_RST, raw_capture_pkg::WIN_H_RST,
            raw_capture_pkg::WIN_V_RST};
        void'($urandom(32'h5809));
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        foreach (rst_tab[i]) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", rd, rst_tab[i]);
        end
        r = $urandom;
        apb(1'b1, raw_capture_pkg::WIN_H_OFS, r);
        apb(1'b0, raw_capture_pkg::WIN_H_OFS, 32'h0);
        chk("window", rd, r);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", {31'h0, er} ^ rd, 32'h1);
        apb(1'b1, raw_capture_pkg::STATUS_OFS, 32'hFFFF_FFFF);
        chk("status write", {31'h0, er}, 32'h1);
        $display("test registers done");
        // corners first: widest inverted words, then packed on the falling edge
        for (int k = 0; k < 10; k++) begin
            r = $urandom;
            if (k == 0) r[15:0] = 16'h8F01;
            if (k == 1) r[15:0] = 16'h0A12;
            capture(r);
        end
        $display("test capture done");
        // generated syncs: 4 pixels a line, 4 half lines, hsync inverted
        apb(1'b1, raw_capture_pkg::SYNC_WIDTH_OFS, 32'h0001_0001);
        apb(1'b1, raw_capture_pkg::FRAME_SIZE_OFS, 32'h0004_0004);
        apb(1'b1, raw_capture_pkg::CTRL_OFS, cw(4'h0, 13'h0014));
        repeat (40) sensor_model_inst.px_q.push_back(15'h0);
        fork
            sensor_model_inst.send_line(1'b0);
            begin
                repeat (150) @(posedge sys_clk);
                repeat (96) begin
                    @(posedge sys_clk);
                    nh += (hs_o === 1'b1);
                    nv += (vs_o === 1'b1);
                end
            end
        join
        @(posedge sys_clk);
        chk("hsync high", 32'(nh), 32'd72);
        chk("vsync high", 32'(nv), 32'd48);
        chk("sync drive", {31'h0, hs_oe}, 32'h1);
        $display("test generator done");
        // field id: direct follows the released pin, latched keeps the vsync value
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, raw_capture_pkg::CTRL_OFS, cw(4'h0, {5'h0, m[1], m[0], 6'h21}));
            f = 1'($urandom);
            repeat (4) sensor_model_inst.px_q.push_back({f, 14'h0});
            sensor_model_inst.send_line(1'b0);
            repeat (10) @(posedge sys_clk);
            chk("field", {31'h0, field_id}, {31'h0, (m[0] ? f : ~f) ^ m[1]});
        end
        $display("test field done");
        end_of_test();
    end
endmodule
